// [rtl/blit_extent_defines.svh]
// Offsets, field positions, masks and reset values of the operand registers
`ifndef BLIT_EXTENT_DEFINES_SVH
`define BLIT_EXTENT_DEFINES_SVH

`define PAT_BASE_OFF 23'h400014
`define SRC_BASE_OFF 23'h400018
`define DST_BASE_OFF 23'h40001C
`define DST_EXTENT_OFF 23'h400020
`define SRC_BG_OFF 23'h400024
`define ALIAS_BIT 23
`define REG_COUNT 5

`define PAT_MASK 32'h007FFFF8
`define ADDR_MASK 32'h007FFFFF
`define EXTENT_MASK 32'h1FFF1FFF
`define COLOR_MASK 32'h00FFFFFF
`define REG_RESET 32'h00000000

`define ADDR_MSB 22
`define PAT_LSB 3
`define HEIGHT_MSB 28
`define HEIGHT_LSB 16
`define WIDTH_MSB 12

`define MONO_PAT_BYTES 9'h008
`define PAT8_BYTES 9'h040
`define PAT16_BYTES 9'h080
`define PAT24_BYTES 9'h100
`define ROW24_FETCH 6'h18
`define ROW24_STRIDE 6'h20

`endif

// [rtl/blit_extent_pkg.sv]
// Types shared by the operand register files
package blit_extent_pkg;
    typedef enum logic [1:0]
    {
        DEPTH_8 = 2'h0,
        DEPTH_16 = 2'h1,
        DEPTH_24 = 2'h3
    } depth_e;
endpackage

// [rtl/expand_color_mask.sv]
// Color masking by configured pixel depth
`timescale 1ns/100ps
module expand_color_mask
(
    input wire logic [1:0] i_depth,
    input wire logic [23:0] i_color,
    output logic [23:0] o_color
);
    // --------------------------------
    // Depth select
    // --------------------------------
    wire is24 = (i_depth == blit_extent_pkg::DEPTH_24);
    wire is16 = (i_depth == blit_extent_pkg::DEPTH_16);
    wire [23:0] keep_mask = is24 ? 24'hFFFFFF : (is16 ? 24'h00FFFF : 24'h0000FF);
    assign o_color = i_color & keep_mask;
endmodule // expand_color_mask

// [rtl/blit_operand_extent_regs.sv]
// Operand address, extent and background color registers of the block-transfer engine
//
// Contract
// - Pattern offset stored in bits 22-3
// - Reserved bits always read back zero
// - Pattern is 8x8 pixels, size by depth
// - 24bpp row fetch reads 24, skips 8
// - Frame-buffer source uses 23-bit offset
// - Host color source uses bits 2-0 only
// - Host mono source ignores source register
// - Destination holds 23-bit frame-buffer offset
// - Extent bits 28-16 give scan lines
// - Extent bits 12-0 give byte width
// - Bit 27 picks source background register
// - Background width follows configured depth
// - Two aliased offsets, word or doubleword
// - Control bit 10 selects host source
// - Control bit 12 marks mono source
// - Control bit 18 marks mono pattern
`timescale 1ns/100ps
`include "blit_extent_defines.svh"
module blit_operand_extent_regs
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_mem_sel,
    input wire logic i_mem_wr,
    input wire logic [23:0] i_mem_addr,
    input wire logic [3:0] i_mem_be,
    input wire logic [31:0] i_mem_wdata,
    output logic [31:0] o_mem_rdata,
    output logic o_mem_ack,
    input wire logic i_src_from_host,
    input wire logic i_src_mono,
    input wire logic i_pat_mono,
    input wire logic i_src_bg_select,
    input wire logic [1:0] i_depth,
    input wire logic [23:0] i_shared_bg,
    output logic [22:0] o_pat_offset,
    output logic [8:0] o_pat_bytes,
    output logic [5:0] o_pat_row_fetch,
    output logic [5:0] o_pat_row_stride,
    output logic [22:0] o_src_offset,
    output logic [2:0] o_src_first_byte,
    output logic o_src_addr_used,
    output logic [22:0] o_dst_offset,
    output logic [12:0] o_dst_height,
    output logic [12:0] o_dst_width,
    output logic [23:0] o_src_expand_bg,
    output logic [23:0] o_pat_expand_bg
);
    // --------------------------------
    // Register storage and decode
    // --------------------------------
    logic [31:0] regs_r [`REG_COUNT];
    logic [31:0] rdata_nxt;
    logic [31:0] rd_mask;
    logic [`REG_COUNT-1:0] hit;
    localparam logic [22:0] OFFS [`REG_COUNT] = '{`PAT_BASE_OFF, `SRC_BASE_OFF,
        `DST_BASE_OFF, `DST_EXTENT_OFF, `SRC_BG_OFF};
    localparam logic [31:0] MASKS [`REG_COUNT] = '{`PAT_MASK, `ADDR_MASK,
        `ADDR_MASK, `EXTENT_MASK, `COLOR_MASK};

    // Bit 23 of the address is not decoded, giving the alias
    genvar g;
    generate
        for (g = 0; g < `REG_COUNT; g++)
        begin : g_dec
            assign hit[g] = (i_mem_addr[`ALIAS_BIT-1:2] == OFFS[g][`ALIAS_BIT-1:2]);
        end
    endgenerate

    // Only low word, high word or whole doubleword lanes are accepted
    wire be_ok = (i_mem_be == 4'h3) || (i_mem_be == 4'hC) || (i_mem_be == 4'hF);
    wire wr_go = i_mem_sel && i_mem_wr && be_ok && !o_mem_ack;
    wire [31:0] lane_mask = {{8{i_mem_be[3]}}, {8{i_mem_be[2]}}, {8{i_mem_be[1]}},
        {8{i_mem_be[0]}}};

    always_comb
    begin
        rdata_nxt = 32'h00000000;
        rd_mask = 32'h00000000;
        for (int i = 0; i < `REG_COUNT; i++)
        begin
            if (hit[i])
            begin
                rdata_nxt = regs_r[i] & MASKS[i];
                rd_mask = MASKS[i];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
            begin
                regs_r[i] <= `REG_RESET;
            end
        end
        else if (i_ce && wr_go)
        begin
            for (int i = 0; i < `REG_COUNT; i++)
            begin
                if (hit[i])
                begin
                    // Reserved and unselected lanes keep their stored value
                    regs_r[i] <= (regs_r[i] & ~(lane_mask & MASKS[i]))
                        | (i_mem_wdata & lane_mask & MASKS[i]);
                end
            end
        end
    end

    // --------------------------------
    // Bus answer
    // --------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_mem_rdata <= 32'h00000000;
            o_mem_ack <= 1'b0;
        end
        else if (i_ce)
        begin
            o_mem_ack <= i_mem_sel && !o_mem_ack;
            o_mem_rdata <= (i_mem_sel && !i_mem_wr && !o_mem_ack) ? rdata_nxt : 32'h00000000;
        end
    end

    // --------------------------------
    // Engine-facing decode
    // --------------------------------
    wire [31:0] pat_w = regs_r[0];
    wire [31:0] src_w = regs_r[1];
    wire [31:0] dst_w = regs_r[2];
    wire [31:0] ext_w = regs_r[3];
    wire [31:0] sbg_w = regs_r[4];
    wire is24 = (i_depth == blit_extent_pkg::DEPTH_24);
    wire is16 = (i_depth == blit_extent_pkg::DEPTH_16);

    wire [8:0] pat_bytes_nxt = i_pat_mono ? `MONO_PAT_BYTES :
        (is24 ? `PAT24_BYTES : (is16 ? `PAT16_BYTES : `PAT8_BYTES));
    wire [5:0] row_fetch_nxt = i_pat_mono ? 6'h01 :
        (is24 ? `ROW24_FETCH : (is16 ? 6'h10 : 6'h08));
    wire [5:0] row_stride_nxt = is24 && !i_pat_mono ? `ROW24_STRIDE : row_fetch_nxt;

    wire host_mono = i_src_from_host && i_src_mono;
    wire [22:0] src_off_nxt = i_src_from_host ? 23'h000000 :
        src_w[`ADDR_MSB:0];
    wire [2:0] first_byte_nxt = (i_src_from_host && !i_src_mono) ? src_w[2:0] : 3'h0;
    wire used_nxt = !host_mono;

    wire [23:0] src_bg_raw = i_src_bg_select ? sbg_w[23:0] : i_shared_bg;
    wire [23:0] src_bg_nxt;
    wire [23:0] pat_bg_nxt;

    expand_color_mask u_src_mask
    (
        .i_depth(i_depth),
        .i_color(src_bg_raw),
        .o_color(src_bg_nxt)
    );

    expand_color_mask u_pat_mask
    (
        .i_depth(i_depth),
        .i_color(i_shared_bg),
        .o_color(pat_bg_nxt)
    );

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_pat_offset <= 23'h000000;
            o_pat_bytes <= `MONO_PAT_BYTES;
            o_pat_row_fetch <= 6'h01;
            o_pat_row_stride <= 6'h01;
            o_src_offset <= 23'h000000;
            o_src_first_byte <= 3'h0;
            o_src_addr_used <= 1'b1;
            o_dst_offset <= 23'h000000;
            o_dst_height <= 13'h0000;
            o_dst_width <= 13'h0000;
            o_src_expand_bg <= 24'h000000;
            o_pat_expand_bg <= 24'h000000;
        end
        else if (i_ce)
        begin
            o_pat_offset <= {pat_w[`ADDR_MSB:`PAT_LSB], 3'h0};
            o_pat_bytes <= pat_bytes_nxt;
            o_pat_row_fetch <= row_fetch_nxt;
            o_pat_row_stride <= row_stride_nxt;
            o_src_offset <= src_off_nxt;
            o_src_first_byte <= first_byte_nxt;
            o_src_addr_used <= used_nxt;
            o_dst_offset <= dst_w[`ADDR_MSB:0];
            o_dst_height <= ext_w[`HEIGHT_MSB:`HEIGHT_LSB];
            o_dst_width <= ext_w[`WIDTH_MSB:0];
            o_src_expand_bg <= src_bg_nxt;
            o_pat_expand_bg <= pat_bg_nxt;
        end
    end

    // --------------------------------
    // Assertions
    // --------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence s_read_req;
        i_ce && i_mem_sel && !i_mem_wr && !o_mem_ack;
    endsequence

    sequence s_full_write(logic [22:0] off);
        i_ce && i_mem_sel && i_mem_wr && (i_mem_be == 4'hF)
            && (i_mem_addr[22:0] == off) && !o_mem_ack;
    endsequence

    a_pat_low_zero: assert property ((regs_r[0][2:0] == 3'h0) && (o_pat_offset[2:0] == 3'h0))
        else $error("pattern offset low bits not zero");

    a_read_reserved: assert property (s_read_req |=>
        ((o_mem_rdata & ~$past(rd_mask)) == 32'h00000000))
        else $error("reserved read bits not zero");

    a_rdata_idle: assert property (!o_mem_ack |-> (o_mem_rdata == 32'h00000000))
        else $error("read data outside answer cycle");

    a_ce_freeze: assert property (!i_ce |=>
        $stable(o_mem_ack) && $stable(o_pat_bytes) && $stable(o_dst_offset))
        else $error("state moved while clock enable low");

    a_pat24_bytes: assert property (i_ce && is24 && !i_pat_mono |=>
        (o_pat_bytes == `PAT24_BYTES) && (o_pat_row_fetch == `ROW24_FETCH)
        && (o_pat_row_stride == `ROW24_STRIDE))
        else $error("24bpp pattern row fetch wrong");

    a_mono_pat_size: assert property (i_ce && i_pat_mono |=>
        o_pat_bytes == `MONO_PAT_BYTES)
        else $error("mono pattern size wrong");

    a_host_mono_src: assert property (i_ce && i_src_from_host && i_src_mono |=>
        !o_src_addr_used && (o_src_offset == 23'h000000) && (o_src_first_byte == 3'h0))
        else $error("host mono source used register");

    a_host_color_src: assert property (i_ce && i_src_from_host && !i_src_mono |=>
        (o_src_first_byte == $past(src_w[2:0])) && (o_src_offset == 23'h000000))
        else $error("host color first byte wrong");

    a_dst_write_seen: assert property (s_full_write(`DST_BASE_OFF) ##1 i_ce |=>
        o_dst_offset == $past(i_mem_wdata[22:0], 2))
        else $error("destination offset not updated");

    a_extent_split: assert property (s_full_write(`DST_EXTENT_OFF) ##1 i_ce |=>
        (o_dst_height == $past(i_mem_wdata[28:16], 2))
        && (o_dst_width == $past(i_mem_wdata[12:0], 2)))
        else $error("extent fields wrong");

    a_bg_select: assert property (i_ce && i_src_bg_select && is24 |=>
        o_src_expand_bg == $past(sbg_w[23:0]))
        else $error("source background not selected");

    a_bg_depth8: assert property (i_ce |=> o_pat_expand_bg[23:8] == 16'h0000
        || $past(i_depth) != blit_extent_pkg::DEPTH_8)
        else $error("8bpp background not masked");

    a_ack_once: assert property (s_read_req |=> o_mem_ack ##1 (!o_mem_ack || !$past(i_ce)))
        else $error("bus answer not one cycle");
endmodule // blit_operand_extent_regs

// [verification/host_cpu_model.sv]
// Host processor model issuing register accesses over the memory bus
`timescale 1ns/100ps
module host_cpu_model
(
    input wire logic i_mclk,
    output logic o_sel,
    output logic o_wr,
    output logic [23:0] o_addr,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata,
    input wire logic [31:0] i_rdata,
    input wire logic i_ack
);
    initial
    begin
        o_sel = 1'b0;
        o_wr = 1'b0;
        o_addr = 24'h000000;
        o_be = 4'h0;
        o_wdata = 32'h00000000;
    end

    // ----------------------------------------
    // One access, held until acknowledged or 8 cycles pass
    // ----------------------------------------
    task automatic access(input logic wr, input logic [23:0] addr, input logic [3:0] be,
        input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 32'h00000000;
        @(posedge i_mclk);
        o_sel <= 1'b1;
        o_wr <= wr;
        o_addr <= addr;
        o_be <= be;
        o_wdata <= wdata;
        while (!ok && n < 8)
        begin
            @(posedge i_mclk);
            n++;
            if (i_ack === 1'b1)
            begin
                ok = 1'b1;
                rdata = i_rdata;
            end
        end
        o_sel <= 1'b0;
        o_addr <= ~addr;
        o_wdata <= ~wdata;
    endtask
endmodule // host_cpu_model

// [verification/blit_operand_extent_regs_tb.sv]
// Self-checking testbench of the operand register bank
`timescale 1ns/100ps
`include "blit_extent_defines.svh"
module blit_operand_extent_regs_tb;
    logic i_mclk = 1'b0;
    logic i_nrst, i_ce, i_src_from_host, i_src_mono, i_pat_mono, i_src_bg_select;
    logic [1:0] i_depth;
    logic [23:0] i_shared_bg;
    logic sel, wr, ack;
    logic [23:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    logic [22:0] o_pat_offset, o_src_offset, o_dst_offset;
    logic [8:0] o_pat_bytes;
    logic [5:0] o_pat_row_fetch, o_pat_row_stride;
    logic [2:0] o_src_first_byte;
    logic o_src_addr_used;
    logic [12:0] o_dst_height, o_dst_width;
    logic [23:0] o_src_expand_bg, o_pat_expand_bg;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    logic [22:0] offs [5] = '{`PAT_BASE_OFF, `SRC_BASE_OFF, `DST_BASE_OFF, `DST_EXTENT_OFF,
        `SRC_BG_OFF};
    logic [31:0] masks [5] = '{`PAT_MASK, `ADDR_MASK, `ADDR_MASK, `EXTENT_MASK, `COLOR_MASK};
    logic [8:0] pbytes [4] = '{9'h008, 9'h040, 9'h080, 9'h100};
    logic [5:0] pfetch [4] = '{6'h01, 6'h08, 6'h10, 6'h18};
    logic [5:0] pstride [4] = '{6'h01, 6'h08, 6'h10, 6'h20};
    logic [1:0] pdep [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
    logic [23:0] dmask [4] = '{24'h0000FF, 24'h0000FF, 24'h00FFFF, 24'hFFFFFF};

    always #2.5 i_mclk = ~i_mclk;

    host_cpu_model i_host_cpu_model (.i_mclk(i_mclk), .o_sel(sel), .o_wr(wr), .o_addr(addr),
        .o_be(be), .o_wdata(wdata), .i_rdata(rdata), .i_ack(ack));

    blit_operand_extent_regs i_blit_operand_extent_regs (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_ce(i_ce), .i_mem_sel(sel), .i_mem_wr(wr), .i_mem_addr(addr), .i_mem_be(be),
        .i_mem_wdata(wdata), .o_mem_rdata(rdata), .o_mem_ack(ack),
        .i_src_from_host(i_src_from_host), .i_src_mono(i_src_mono), .i_pat_mono(i_pat_mono),
        .i_src_bg_select(i_src_bg_select), .i_depth(i_depth), .i_shared_bg(i_shared_bg),
        .o_pat_offset(o_pat_offset), .o_pat_bytes(o_pat_bytes),
        .o_pat_row_fetch(o_pat_row_fetch), .o_pat_row_stride(o_pat_row_stride),
        .o_src_offset(o_src_offset), .o_src_first_byte(o_src_first_byte),
        .o_src_addr_used(o_src_addr_used), .o_dst_offset(o_dst_offset),
        .o_dst_height(o_dst_height), .o_dst_width(o_dst_width),
        .o_src_expand_bg(o_src_expand_bg), .o_pat_expand_bg(o_pat_expand_bg));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results();
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wreg(input logic [22:0] off, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] r;
        logic ok;
        i_host_cpu_model.access(1'b1, {1'b0, off}, b, d, r, ok);
        chk("write ack", 32'h00000001, 32'(ok));
        chk("write rdata", 32'h00000000, r);
    endtask

    task automatic rreg(input logic hi, input logic [22:0] off, input logic [31:0] exp);
        logic [31:0] r;
        logic ok;
        i_host_cpu_model.access(1'b0, {hi, off}, 4'hF, 32'h00000000, r, ok);
        chk("read ack", 32'h00000001, 32'(ok));
        chk("read data", exp, r);
    endtask

    task automatic cfg(input logic h, input logic sm, input logic pm, input logic bs,
        input logic [1:0] d);
        @(posedge i_mclk);
        i_src_from_host <= h;
        i_src_mono <= sm;
        i_pat_mono <= pm;
        i_src_bg_select <= bs;
        i_depth <= d;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            results();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        int i;
        int k;
        i_nrst = 1'b0;
        i_ce = 1'b1;
        i_src_from_host = 1'b0;
        i_src_mono = 1'b0;
        i_pat_mono = 1'b0;
        i_src_bg_select = 1'b0;
        i_depth = 2'h0;
        i_shared_bg = 24'hABCDEF;
        repeat (16) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1;
        chk("pattern bytes", 32'h00000008, 32'(o_pat_bytes));
        chk("source used", 32'h00000001, 32'(o_src_addr_used));
        for (i = 0; i < 5; i++)
        begin
            rreg(1'b0, offs[i], `REG_RESET);
            wreg(offs[i], 4'hF, 32'hFFFFFFFF);
            rreg(1'b1, offs[i], masks[i]);
        end
        wreg(`PAT_BASE_OFF, 4'hF, 32'hFF5A5F07);
        wreg(`DST_BASE_OFF, 4'h3, 32'hAAAA1234);
        wreg(`DST_BASE_OFF, 4'hC, 32'h00569999);
        wreg(`DST_BASE_OFF, 4'h1, 32'hFFFFFFFF);
        rreg(1'b1, `DST_BASE_OFF, 32'h00561234);
        wreg(`DST_EXTENT_OFF, 4'hF, 32'hF0ABF123);
        wreg(`SRC_BASE_OFF, 4'hF, 32'hFF12345D);
        wreg(`SRC_BG_OFF, 4'hF, 32'hFF123456);
        rreg(1'b0, 23'h400030, 32'h00000000);
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
        chk("pattern offset", 32'h005A5F00, 32'(o_pat_offset));
        chk("dest offset", 32'h00561234, 32'(o_dst_offset));
        chk("dest height", 32'h000010AB, 32'(o_dst_height));
        chk("dest width", 32'h00001123, 32'(o_dst_width));
        chk("source offset", 32'h0012345D, 32'(o_src_offset));
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
        chk("first byte", 32'h00000005, 32'(o_src_first_byte));
        chk("host offset", 32'h00000000, 32'(o_src_offset));
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        chk("mono used", 32'h00000000, 32'(o_src_addr_used));
        for (k = 0; k < 4; k++)
        begin
            cfg(1'b0, 1'b0, k == 0, 1'b0, pdep[k]);
            chk("pat bytes", 32'(pbytes[k]), 32'(o_pat_bytes));
            chk("pat fetch", 32'(pfetch[k]), 32'(o_pat_row_fetch));
            chk("pat stride", 32'(pstride[k]), 32'(o_pat_row_stride));
            for (i = 0; i < 2; i++)
            begin
                cfg(1'b0, 1'b1, 1'b0, i == 1, pdep[k]);
                chk("src bg", 32'((i == 1 ? 24'h123456 : 24'hABCDEF) & dmask[k]),
                    32'(o_src_expand_bg));
                chk("pat bg", 32'(24'hABCDEF & dmask[k]), 32'(o_pat_expand_bg));
            end
        end
        @(posedge i_mclk);
        i_ce <= 1'b0;
        cfg(1'b0, 1'b1, 1'b1, 1'b1, pdep[3]);
        chk("frozen pat bytes", 32'h00000100, 32'(o_pat_bytes));
        @(posedge i_mclk);
        i_ce <= 1'b1;
        cfg(1'b0, 1'b1, 1'b1, 1'b1, pdep[3]);
        chk("thawed pat bytes", 32'h00000008, 32'(o_pat_bytes));
        results();
    end
endmodule // blit_operand_extent_regs_tb
